/* File: shared/pmc_pkg.sv */
// Types shared by the register bank and whoever instantiates it.
// Assumes the constants header is found by bare name.
package pmc_pkg;
  // =====================================================================
  // Charger event levels, one bit per flag of the first flag register.
  typedef struct packed {
    logic batHot;     // Battery too hot.
    logic batCold;    // Battery too cold.
    logic overVolt;   // Input overvoltage.
    logic chgActive;  // Charge running.
    logic inGood;     // Charger input good.
    logic vbatComp;   // Battery comparator output.
    logic thermReg;   // Thermal regulation loop active.
  } pmc_chg_evt_type;
  // Release-delay sequencer states, one-hot.
  typedef enum logic [1:0] {
    PMC_WAIT = 2'b01,
    PMC_DONE = 2'b10
  } pmc_dly_state_type;
endpackage : pmc_pkg

/* File: shared/pmc_regs.svh */
// Register offsets, field positions, reset values and timing figures.
// Assumes inclusion by bare name from the design file.
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_ADDR_CTRL 8'h0a
`define PMC_ADDR_LEVEL 8'h0b
`define PMC_ADDR_DIR 8'h0c
`define PMC_ADDR_MASK0 8'h0d
`define PMC_ADDR_MASK1 8'h0e
`define PMC_ADDR_MASK2 8'h0f
`define PMC_ADDR_FLAG0 8'h10
`define PMC_ADDR_FLAG1 8'h11
`define PMC_ADDR_FLAG2 8'h12
`define PMC_CTRL_HOLD 5
`define PMC_CTRL_BTN 4
`define PMC_CTRL_SEL 2
`define PMC_CTRL_AMP 1
`define PMC_CTRL_DLY 0
`define PMC_RST_CTRL 8'h05
`define PMC_RST_LEVEL 4'hf
`define PMC_RST_DIR 8'hf3
`define PMC_DIR_FIXED 8'h30
`define PMC_DIR_WMASK 8'hcf
`define PMC_RST_MASK 8'hff
`define PMC_MASK2_FIXED 8'h01
`define PMC_FLAG0_RSVD 8'h10
`define PMC_FLAG2_RSVD 8'h01
`define PMC_DLY_SHORT_MS 11
`define PMC_DLY_LONG_MS 90
`define PMC_CLK_KHZ 40000
`define PMC_DEBOUNCE_CYC 32
`define PMC_BTN_IDLE 1'b1
`endif

/* File: testbench/pmc_host_model.sv */
// Host processor model that drives the register strobe port.
// Assumes one sys_clk shared with the register bank.
`timescale 1ns/10ps
module pmc_host_model (
  input wire logic sys_clk,
  input wire logic regRdValid_q,
  input wire logic [7:0] regRdData_q,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  output logic hostTimeout
);
  // ====================
  // Idle state. Released lines show inverted values, so stale data never
  // looks like a valid request.
  initial begin
    regAddr = 8'hff;
    regWrData = 8'hff;
    regWrite = 1'b0;
    regRead = 1'b0;
    hostTimeout = 1'b0;
  end

  // One write strobe, then an idle cycle so strobes never merge.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    regAddr = addr;
    regWrData = data;
    regWrite = 1'b1;
    @(posedge sys_clk);
    #1;
    regWrite = 1'b0;
    regAddr = ~addr;
    regWrData = ~data;
    @(posedge sys_clk);
    #1;
  endtask : wr

  // One read strobe; the answer is awaited for a bounded number of cycles.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    int k;
    data = 8'hxx;
    regAddr = addr;
    regRead = 1'b1;
    @(posedge sys_clk);
    #1;
    regRead = 1'b0;
    regAddr = ~addr;
    // Valid stands only in the cycle after the taking edge, so it is looked
    // at before stepping on.
    for (k = 0; k < 4; k++) begin
      if (regRdValid_q === 1'b1) begin
        data = regRdData_q;
        break;
      end
      @(posedge sys_clk);
      #1;
    end
    // Let one edge pass so a following strobe never lands in this step.
    @(posedge sys_clk);
    #1;
    if (k == 4) begin
      hostTimeout = 1'b1;
    end
  endtask : rd
endmodule : pmc_host_model

/* File: testbench/test_pmic_control_gpio_irq_regs.sv */
// Self-checking bench for the control, pin and interrupt register bank.
// Assumes the host model file; delays and debounce are shortened.
`timescale 1ns/10ps
module test_pmic_control_gpio_irq_regs
  import pmc_pkg::*;
;
  localparam int SHORT = 20; // Short release delay in cycles.
  localparam int LONG = 50; // Long release delay in cycles.
  logic sys_clk, rstn, regWrite, regRead, buttonInN, hostTimeout;
  logic [7:0] regAddr, regWrData, regRdData_q, chgState, d, e;
  logic regRdValid_q, pgoodzBuck, vbatCompEnable, regulatorOn_q;
  logic measSelTemp_q, measAmpOn_q, resetRelease_q, irqN_q;
  logic pgoodzLinear;
  logic [3:0] gpioIn, gpioOut_q, gpioOe_q;
  logic [3:2] ledDrive_q;
  pmc_chg_evt_type chgEvt;
  int miscompares = 0;
  int nTests = 0;

  // ====================
  pmc_control_gpio_irq_regs #(.SHORT_CYC(SHORT), .LONG_CYC(LONG),
    .DEBOUNCE_CYC(4)) i_pmc_control_gpio_irq_regs (.sys_clk(sys_clk),
    .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q), .buttonInN(buttonInN), .chgEvt(chgEvt),
    .chgState(chgState), .pgoodzBuck(pgoodzBuck),
    .pgoodzLinear(pgoodzLinear),
    .vbatCompEnable(vbatCompEnable), .gpioIn(gpioIn),
    .gpioOut_q(gpioOut_q), .gpioOe_q(gpioOe_q), .ledDrive_q(ledDrive_q),
    .regulatorOn_q(regulatorOn_q), .measSelTemp_q(measSelTemp_q),
    .measAmpOn_q(measAmpOn_q), .resetRelease_q(resetRelease_q),
    .irqN_q(irqN_q));
  pmc_host_model i_pmc_host_model (.sys_clk(sys_clk),
    .regRdValid_q(regRdValid_q), .regRdData_q(regRdData_q),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .hostTimeout(hostTimeout));

  // ====================
  // Clock, and a hung host read cuts the run short.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge hostTimeout) begin
    miscompares++;
    end_sim();
  end

  // Shared compare, cycle stepping, reset and register helpers.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic do_reset;
    rstn = 1'b0;
    tick(20);
    rstn = 1'b1;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_pmc_host_model.wr(a, v);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] v);
    i_pmc_host_model.rd(a, d);
    check(d, v);
  endtask : rchk
  task automatic end_sim;
    if (miscompares == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // ====================
  // Default register contents and the long release delay.
  task automatic t_reset_values;
    tick(LONG - 10);
    check({7'h0, resetRelease_q}, 8'h00);
    tick(16);
    check({7'h0, resetRelease_q}, 8'h01);
    rchk(8'h0a, 8'h05);
    rchk(8'h0c, 8'hf3);
    rchk(8'h0d, 8'hff);
    rchk(8'h0e, 8'hff);
    rchk(8'h0f, 8'hff);
    rchk(8'h10, 8'h00);
    rchk(8'h20, 8'h00);
    check({6'h0, ledDrive_q}, 8'h03);
    check({6'h0, measSelTemp_q, irqN_q}, 8'h03);
  endtask : t_reset_values

  // A second reset, with the short delay picked while counting.
  task automatic t_short_delay;
    do_reset();
    wr(8'h0a, 8'h04);
    tick(SHORT - 8);
    check({7'h0, resetRelease_q}, 8'h00);
    tick(10);
    check({7'h0, resetRelease_q}, 8'h01);
  endtask : t_short_delay

  // Hold bit and debounced button both power the regulators.
  task automatic t_power;
    wr(8'h0a, 8'h25);
    tick(2);
    check({7'h0, regulatorOn_q}, 8'h01);
    wr(8'h0a, 8'h05);
    tick(2);
    check({7'h0, regulatorOn_q}, 8'h00);
    buttonInN = 1'b0;
    tick(16);
    check({7'h0, regulatorOn_q}, 8'h01);
    wr(8'h0a, 8'h05);
    rchk(8'h0a, 8'h15);
    buttonInN = 1'b1;
    tick(16);
    rchk(8'h0a, 8'h05);
    check({7'h0, regulatorOn_q}, 8'h00);
  endtask : t_power

  // Measurement select, enable, and the input-good override.
  task automatic t_meas;
    wr(8'h0a, 8'h02);
    tick(2);
    check({6'h0, measSelTemp_q, measAmpOn_q}, 8'h01);
    wr(8'h0a, 8'h04);
    tick(2);
    check({6'h0, measSelTemp_q, measAmpOn_q}, 8'h02);
    chgEvt.inGood = 1'b1;
    tick(8);
    check({6'h0, measSelTemp_q, measAmpOn_q}, 8'h03);
    chgEvt.inGood = 1'b0;
    tick(8);
  endtask : t_meas

  // Pin readback, direction, open-drain drive and LED select.
  task automatic t_pins;
    gpioIn = 4'h6;
    tick(8);
    i_pmc_host_model.rd(8'h0b, d);
    check({4'h0, d[3:0]}, 8'h06);
    wr(8'h0c, 8'h00);
    rchk(8'h0c, 8'h30);
    check({6'h0, ledDrive_q}, 8'h00);
    wr(8'h0b, 8'h05);
    tick(2);
    check({gpioOut_q, gpioOe_q}, 8'h0a);
    wr(8'h0c, 8'h0c);
    tick(2);
    check({gpioOut_q, gpioOe_q}, 8'h02);
    wr(8'h0c, 8'hcf);
    rchk(8'h0c, 8'hff);
    check({6'h0, ledDrive_q}, 8'h03);
    wr(8'h0b, 8'h0f);
  endtask : t_pins

  // First flag register: masking, edges, read-clear and interrupt.
  task automatic t_flags0;
    vbatCompEnable = 1'b1;
    chgEvt.batHot = 1'b1;
    tick(8);
    rchk(8'h10, 8'h00);
    check({7'h0, irqN_q}, 8'h01);
    chgEvt = '0;
    tick(8);
    wr(8'h0d, 8'h00);
    for (int i = 0; i < 7; i++) begin
      chgEvt = pmc_chg_evt_type'(7'h01 << i);
      tick(8);
      e = 8'h01 << ((i < 4) ? i : i + 1);
      check({7'h0, irqN_q}, 8'h00);
      rchk(8'h10, e);
      rchk(8'h10, 8'h00);
      check({7'h0, irqN_q}, 8'h01);
      chgEvt = '0;
      tick(8);
      rchk(8'h10, (i == 2 || i == 3) ? e : 8'h00);
    end
    vbatCompEnable = 1'b0;
    chgEvt.vbatComp = 1'b1;
    tick(8);
    rchk(8'h10, 8'h00);
    chgEvt = '0;
    tick(8);
  endtask : t_flags0

  // Charger-state and pin-change flags.
  task automatic t_flags12;
    wr(8'h0e, 8'h00);
    chgState = 8'h81;
    tick(8);
    rchk(8'h11, 8'h81);
    chgState = 8'h00;
    tick(8);
    rchk(8'h11, 8'h00);
    wr(8'h0f, 8'h00);
    rchk(8'h0f, 8'h01);
    gpioIn = 4'h7;
    pgoodzBuck = 1'b1;
    pgoodzLinear = 1'b1;
    tick(8);
    rchk(8'h12, 8'h1c);
    gpioIn = 4'h6;
    pgoodzBuck = 1'b0;
    pgoodzLinear = 1'b0;
    tick(8);
    rchk(8'h12, 8'h10);
    do_reset();
    rchk(8'h0f, 8'hff);
    rchk(8'h0c, 8'hf3);
  endtask : t_flags12

  // ====================
  // Main sequence.
  initial begin
    rstn = 1'b0;
    buttonInN = 1'b1;
    chgEvt = '0;
    chgState = 8'h00;
    pgoodzBuck = 1'b0;
    pgoodzLinear = 1'b0;
    vbatCompEnable = 1'b0;
    gpioIn = 4'hf;
    do_reset();
    t_reset_values();
    t_short_delay();
    t_power();
    t_meas();
    t_pins();
    t_flags0();
    t_flags12();
    end_sim();
  end
endmodule : test_pmic_control_gpio_irq_regs

/* File: verilog/pmc_control_gpio_irq_regs.sv */
// Control, pin and interrupt register bank of the power manager.
// Assumes a serial front end that presents one-cycle read and write
// strobes with an 8-bit address, and analog status lines that are
// asynchronous to sys_clk.
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_control_gpio_irq_regs
  import pmc_pkg::*;
#(
  parameter int SHORT_CYC = `PMC_DLY_SHORT_MS * `PMC_CLK_KHZ,
  parameter int LONG_CYC = `PMC_DLY_LONG_MS * `PMC_CLK_KHZ,
  parameter int DEBOUNCE_CYC = `PMC_DEBOUNCE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData_q,
  output logic regRdValid_q,
  input wire logic buttonInN,
  input wire pmc_chg_evt_type chgEvt,
  input wire logic [7:0] chgState,
  input wire logic pgoodzBuck,
  input wire logic pgoodzLinear,
  input wire logic vbatCompEnable,
  input wire logic [3:0] gpioIn,
  output logic [3:0] gpioOut_q,
  output logic [3:0] gpioOe_q,
  output logic [3:2] ledDrive_q,
  output logic regulatorOn_q,
  output logic measSelTemp_q,
  output logic measAmpOn_q,
  output logic resetRelease_q,
  output logic irqN_q
);
  // =====================================================================
  // Input synchronisers.
  localparam int NIN = 22;  // Width of the gathered asynchronous inputs.
  // The button pin idles high; starting its stages at the idle level keeps
  // the debouncer from seeing a false press right after reset.
  localparam logic [NIN-1:0] SYNC_RST = {{(NIN-1){1'b0}}, `PMC_BTN_IDLE};
  logic [NIN-1:0] rawIn;  // Gathered pin and status levels.
  logic [NIN-1:0] syncA_q;  // First stage, read by the second only.
  logic [NIN-1:0] syncB_q;  // Second stage.
  logic [NIN-1:0] syncC_q;  // Third stage.
  logic [NIN-1:0] filt_q;  // Accepted level.
  logic [NIN-1:0] filtPrev_q;  // Level one cycle earlier, for edges.
  logic [NIN-1:0] rise;  // Rising edges of accepted levels.
  logic [NIN-1:0] both;  // Any change of accepted levels.
  assign rawIn = {gpioIn, chgEvt, chgState, pgoodzBuck, pgoodzLinear,
                  buttonInN};
  assign rise = filt_q & ~filtPrev_q;
  assign both = filt_q ^ filtPrev_q;

  // A change counts only once the second and third stages agree, so a
  // single-cycle glitch on a pin never reaches the flags.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= SYNC_RST;
      syncB_q <= SYNC_RST;
      syncC_q <= SYNC_RST;
      filt_q <= SYNC_RST;
      filtPrev_q <= SYNC_RST;
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      filt_q <= (syncC_q & ~(syncB_q ^ syncC_q)) |
                (filt_q & (syncB_q ^ syncC_q));
      filtPrev_q <= filt_q;
    end
  end

  // Named views of the accepted levels.
  logic [3:0] pinLvl;  // Pin input buffers.
  logic [6:0] evtLvl;  // Charger events, same order as the struct.
  logic [7:0] stLvl;  // Charger states.
  assign pinLvl = filt_q[21:18];
  assign evtLvl = filt_q[17:11];
  assign stLvl = filt_q[10:3];

  // =====================================================================
  // Push-button debounce.
  logic buttonState_q;  // Debounced, high while pressed.
  logic [15:0] dbCnt_q;  // Cycles the new level has held.
  // The input pin is low while pressed; a level must hold for the whole
  // debounce span before the state follows it.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      buttonState_q <= 1'b0;
      dbCnt_q <= '0;
    end else if (buttonState_q == filt_q[0]) begin
      if (dbCnt_q == 16'(DEBOUNCE_CYC - 1)) begin
        buttonState_q <= ~filt_q[0];
        dbCnt_q <= '0;
      end else begin
        dbCnt_q <= dbCnt_q + 16'h0001;
      end
    end else begin
      dbCnt_q <= '0;
    end
  end

  // =====================================================================
  // Register decode helpers.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit
  logic wrCtrl;  // Write to the control register.
  logic wrLevel;  // Write to the pin level register.
  logic wrDir;  // Write to the pin direction register.
  assign wrCtrl = regWrite && hit(regAddr, `PMC_ADDR_CTRL);
  assign wrLevel = regWrite && hit(regAddr, `PMC_ADDR_LEVEL);
  assign wrDir = regWrite && hit(regAddr, `PMC_ADDR_DIR);

  // =====================================================================
  // Control register.
  localparam logic [7:0] CTRL_RST = `PMC_RST_CTRL;  // Control defaults.
  logic hold_q;  // Regulator hold bit.
  logic measSel_q;  // Measurement select bit.
  logic ampEn_q;  // Amplifier enable bit.
  logic dlyLong_q;  // Release delay select bit.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= CTRL_RST[`PMC_CTRL_HOLD];
      measSel_q <= CTRL_RST[`PMC_CTRL_SEL];
      ampEn_q <= CTRL_RST[`PMC_CTRL_AMP];
      dlyLong_q <= CTRL_RST[`PMC_CTRL_DLY];
    end else if (wrCtrl) begin
      // The button bit is not written: it only reports the pin.
      hold_q <= regWrData[`PMC_CTRL_HOLD];
      measSel_q <= regWrData[`PMC_CTRL_SEL];
      ampEn_q <= regWrData[`PMC_CTRL_AMP];
      dlyLong_q <= regWrData[`PMC_CTRL_DLY];
    end
  end

  // Regulator and measurement controls, registered for clean outputs.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regulatorOn_q <= 1'b0;
      measSelTemp_q <= CTRL_RST[`PMC_CTRL_SEL];
      measAmpOn_q <= 1'b0;
    end else begin
      regulatorOn_q <= hold_q | buttonState_q;
      measSelTemp_q <= measSel_q;
      measAmpOn_q <= ampEn_q | evtLvl[2];
    end
  end

  // =====================================================================
  // Reset release delay; the select may change while counting, and the
  // new target is then used at once.
  pmc_dly_state_type dlyState_q;  // Sequencer state.
  logic [21:0] dlyCnt_q;  // Cycles since reset release.
  logic [21:0] dlyTarget;  // Count at which the release happens.
  assign dlyTarget = dlyLong_q ? 22'(LONG_CYC - 1) : 22'(SHORT_CYC - 1);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dlyState_q <= PMC_WAIT;
      dlyCnt_q <= '0;
      resetRelease_q <= 1'b0;
    end else begin
      case (dlyState_q)
        PMC_WAIT: begin
          if (dlyCnt_q >= dlyTarget) begin
            dlyState_q <= PMC_DONE;
            resetRelease_q <= 1'b1;
          end else begin
            dlyCnt_q <= dlyCnt_q + 22'h000001;
          end
        end
        PMC_DONE: begin
          resetRelease_q <= 1'b1;
        end
        default: begin
          dlyState_q <= PMC_WAIT;
        end
      endcase
    end
  end

  // =====================================================================
  // Pin level, direction and LED select.
  logic [3:0] drive_q;  // Written level: 0 pulls low.
  logic [7:0] dir_q;  // Direction and LED select, fixed bits included.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      drive_q <= `PMC_RST_LEVEL;
      dir_q <= `PMC_RST_DIR;
    end else begin
      if (wrLevel) begin
        drive_q <= regWrData[3:0];
      end
      if (wrDir) begin
        dir_q <= (regWrData & `PMC_DIR_WMASK) | `PMC_DIR_FIXED;
      end
    end
  end

  // Open-drain pins: the pin is only ever pulled low, never high.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gpioOut_q <= 4'h0;
      gpioOe_q <= 4'h0;
      ledDrive_q <= 2'h0;
    end else begin
      gpioOut_q <= 4'h0;
      gpioOe_q <= ~dir_q[3:0] & ~drive_q;
      ledDrive_q <= dir_q[7:6];
    end
  end

  // =====================================================================
  // Masks and flags.
  logic [7:0] mask0_q;  // Charger event mask.
  logic [7:0] mask1_q;  // Charger state mask.
  logic [7:0] mask2_q;  // Pin and power event mask.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask0_q <= `PMC_RST_MASK;
      mask1_q <= `PMC_RST_MASK;
      mask2_q <= `PMC_RST_MASK;
    end else if (regWrite) begin
      if (hit(regAddr, `PMC_ADDR_MASK0)) begin
        mask0_q <= regWrData;
      end else if (hit(regAddr, `PMC_ADDR_MASK1)) begin
        mask1_q <= regWrData;
      end else if (hit(regAddr, `PMC_ADDR_MASK2)) begin
        mask2_q <= regWrData | `PMC_MASK2_FIXED;
      end
    end
  end

  logic buttonPrev_q;  // Debounced button one cycle earlier.
  logic buttonStateEdge_q;  // Change of the debounced button.
  logic [7:0] evt0;  // Raw events of the first flag register.
  logic [7:0] evt1;  // Raw events of the charger-state flags.
  logic [7:0] evt2;  // Raw events of the pin and power flags.
  logic [7:0] set0;  // Unmasked events, first register.
  logic [7:0] set1;  // Unmasked events, charger-state register.
  logic [7:0] set2;  // Unmasked events, pin and power register.
  assign evt0 = {rise[17], rise[16], rise[15], 1'b0, both[14], both[13],
                 rise[12] & vbatCompEnable, rise[11]};
  assign evt1 = rise[10:3];
  assign evt2 = {both[21:18], rise[2], rise[1], 1'b0, 1'b0} |
                {6'h00, buttonStateEdge_q, 1'b0};
  assign set0 = evt0 & ~mask0_q & ~`PMC_FLAG0_RSVD;
  assign set1 = evt1 & ~mask1_q;
  assign set2 = evt2 & ~mask2_q & ~`PMC_FLAG2_RSVD;

  // The debounced button is on sys_clk already; its edge is kept here.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      buttonPrev_q <= 1'b0;
      buttonStateEdge_q <= 1'b0;
    end else begin
      buttonPrev_q <= buttonState_q;
      buttonStateEdge_q <= buttonState_q ^ buttonPrev_q;
    end
  end

  logic [7:0] flag0_q;  // First flag register.
  logic [7:0] flag1_q;  // Charger-state flags.
  logic [7:0] flag2_q;  // Pin and power flags.
  logic rd0;  // Read of the first flag register.
  logic rd1;  // Read of the charger-state flags.
  logic rd2;  // Read of the pin and power flags.
  assign rd0 = regRead && hit(regAddr, `PMC_ADDR_FLAG0);
  assign rd1 = regRead && hit(regAddr, `PMC_ADDR_FLAG1);
  assign rd2 = regRead && hit(regAddr, `PMC_ADDR_FLAG2);
  // A read clears every flag it returned; an event arriving in the same
  // cycle is set again, so nothing is lost between read and clear.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag0_q <= 8'h00;
      flag1_q <= 8'h00;
      flag2_q <= 8'h00;
    end else begin
      flag0_q <= (rd0 ? 8'h00 : flag0_q) | set0;
      flag1_q <= (rd1 ? 8'h00 : flag1_q) | set1;
      flag2_q <= (rd2 ? 8'h00 : flag2_q) | set2;
    end
  end

  // Interrupt line, low while any flag is pending.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqN_q <= 1'b1;
    end else begin
      irqN_q <= ~(|{flag0_q, flag1_q, flag2_q});
    end
  end

  // =====================================================================
  // Read data, one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData_q <= 8'h00;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRead;
      if (!regRead) begin
        regRdData_q <= regRdData_q;
      end else if (hit(regAddr, `PMC_ADDR_CTRL)) begin
        regRdData_q <= {2'b00, hold_q, buttonState_q, 1'b0, measSel_q,
                        ampEn_q, dlyLong_q};
      end else if (hit(regAddr, `PMC_ADDR_LEVEL)) begin
        regRdData_q <= {4'h0, pinLvl};
      end else if (hit(regAddr, `PMC_ADDR_DIR)) begin
        regRdData_q <= dir_q;
      end else if (hit(regAddr, `PMC_ADDR_MASK0)) begin
        regRdData_q <= mask0_q;
      end else if (hit(regAddr, `PMC_ADDR_MASK1)) begin
        regRdData_q <= mask1_q;
      end else if (hit(regAddr, `PMC_ADDR_MASK2)) begin
        regRdData_q <= mask2_q;
      end else if (rd0) begin
        regRdData_q <= flag0_q;
      end else if (rd1) begin
        regRdData_q <= flag1_q;
      end else if (rd2) begin
        regRdData_q <= flag2_q;
      end else begin
        regRdData_q <= 8'h00;
      end
    end
  end

  // =====================================================================
  // Assertions.
  property p_reg_on;
    @(posedge sys_clk) disable iff (!rstn)
    (hold_q | buttonState_q) |=> regulatorOn_q;
  endproperty
  a_reg_on: assert property (p_reg_on)
    else $error("Regulators off although hold or button is set.");

  property p_btn_ro;
    @(posedge sys_clk) disable iff (!rstn)
    (wrCtrl && (dbCnt_q != 16'(DEBOUNCE_CYC - 1))) |=>
      $stable(buttonState_q);
  endproperty
  a_btn_ro: assert property (p_btn_ro)
    else $error("Button state changed by a register write.");

  property p_sel;
    @(posedge sys_clk) disable iff (!rstn)
    wrCtrl |=> ##1 (measSelTemp_q == $past(regWrData[`PMC_CTRL_SEL], 2));
  endproperty
  a_sel: assert property (p_sel)
    else $error("Measurement select does not follow the written bit.");

  property p_amp;
    @(posedge sys_clk) disable iff (!rstn)
    (evtLvl[2] && !ampEn_q) |=> measAmpOn_q;
  endproperty
  a_amp: assert property (p_amp)
    else $error("Amplifier not enabled by input-good.");

  property p_dly;
    @(posedge sys_clk) disable iff (!rstn)
    (!resetRelease_q && dlyCnt_q < dlyTarget) |=> !resetRelease_q;
  endproperty
  a_dly: assert property (p_dly)
    else $error("Reset released before the selected delay.");

  property p_pin;
    @(posedge sys_clk) disable iff (!rstn)
    wrLevel |=> ##1 (gpioOe_q == (~dir_q[3:0] & ~$past(regWrData[3:0], 2)));
  endproperty
  a_pin: assert property (p_pin)
    else $error("Pin drive does not follow level and direction.");

  property p_led;
    @(posedge sys_clk) disable iff (!rstn)
    wrDir |=> ##1 (ledDrive_q == $past(regWrData[7:6], 2));
  endproperty
  a_led: assert property (p_led)
    else $error("LED select does not follow the written bits.");

  property p_mask;
    @(posedge sys_clk) disable iff (!rstn)
    (mask0_q[7] && (rd0 || !flag0_q[7])) |=> !flag0_q[7];
  endproperty
  a_mask: assert property (p_mask)
    else $error("Masked event set its flag.");

  property p_hot;
    @(posedge sys_clk) disable iff (!rstn)
    (rise[17] && !mask0_q[7]) |=> flag0_q[7];
  endproperty
  a_hot: assert property (p_hot)
    else $error("Unmasked hot event did not set its flag.");

  property p_rc;
    @(posedge sys_clk) disable iff (!rstn)
    (rd0 && set0 == 8'h00) |=> (flag0_q == 8'h00);
  endproperty
  a_rc: assert property (p_rc)
    else $error("Flags not cleared by a read.");

  property p_vbat;
    @(posedge sys_clk) disable iff (!rstn)
    (!vbatCompEnable && (rd0 || !flag0_q[1])) |=> !flag0_q[1];
  endproperty
  a_vbat: assert property (p_vbat)
    else $error("Disabled comparator raised its flag.");

  property p_pinchg;
    @(posedge sys_clk) disable iff (!rstn)
    (both[18] && !mask2_q[4]) |=> flag2_q[4];
  endproperty
  a_pinchg: assert property (p_pinchg)
    else $error("Pin change did not set its flag.");

  property p_state;
    @(posedge sys_clk) disable iff (!rstn)
    (rise[3] && !mask1_q[0]) |=> flag1_q[0];
  endproperty
  a_state: assert property (p_state)
    else $error("Charger state edge did not set its flag.");

  property p_irq;
    @(posedge sys_clk) disable iff (!rstn)
    (|flag0_q) |=> !irqN_q;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt not asserted with a pending flag.");
endmodule : pmc_control_gpio_irq_regs
